// ===== design/ipl_map.vh
// constants for the inter-processor packet link
// ----------------------------------------------------------------------
// Notes on behaviour
// [R1] every packet opens with start delimiter bytes 0xef then 0xbe
// [R2] one command byte follows the start delimiter
// [R3] length byte follows command; exactly that many payload bytes follow
// [R4] payload at most 255 bytes; zero length allowed
// [R5] crc-8 poly 0x31, init 0xff, no final xor, checked on receive
// [R6] end delimiter 0x0d follows the crc byte
// [R7] serial link 115200 baud, 8 data bits, no parity, one stop bit
// [R8] receive path buffers at least 32 bytes
// [R9] command and payload released only after crc and end are verified
// [R10] wait for received packets is bounded by a timeout, flagged as error
// [R11] point-to-point only, no addressing
// [R12] after reset initialise framing path, then enter synchronisation
// [R13] synchronisation sends handshake with version string
// [R14] after handshake move to local parameter exchange
// [R15] peer waits for device to reconnect after device restart
// [R16] handshake command 0x02, payload is pattern then version
// [R17] local then model parameter exchange, then operation state
// [R18] bad crc or end byte drops packet, search restarts
// [R19] crc over cmd, length, payload msb first; timeout configurable
// ----------------------------------------------------------------------
`ifndef IPL_MAP_VH
`define IPL_MAP_VH
`define IPL_CLK_HZ      20000000
`define IPL_BAUD        115200
`define IPL_BIT_CYC     (`IPL_CLK_HZ / `IPL_BAUD)
`define IPL_SOF0        8'hef
`define IPL_SOF1        8'hbe
`define IPL_EOF         8'h0d
`define IPL_CRC_POLY    8'h31
`define IPL_CRC_INIT    8'hff
`define IPL_CRC_XOR     8'h00
`define IPL_CMD_HELLO   8'h02
`define IPL_FIFO_DEPTH  32
`define IPL_TIMEOUT_CYC 2000000
`endif

// ===== design/ipl_fifo.v
// parameterised synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module ipl_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 5
) (
  input  wire             i_clk,
  input  wire             i_sys_rst,
  input  wire [WIDTH-1:0] i_data,
  input  wire             i_valid,
  output wire             o_ready,
  output wire [WIDTH-1:0] o_data,
  output wire             o_valid,
  input  wire             i_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr;
  reg [AW:0]      rd_ptr;
  reg [AW:0]      count;
  wire            do_wr;
  wire            do_rd;

  assign o_ready = (count != DEPTH[AW:0]);
  assign o_valid = (count != {(AW+1){1'b0}});
  assign o_data  = mem[rd_ptr[AW-1:0]];
  assign do_wr   = i_valid & o_ready;
  assign do_rd   = o_valid & i_ready;

  always @(posedge i_clk) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= i_data;
    end
  end

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr[AW-1:0] == DEPTH[AW-1:0] - 1'b1) ?
                  {(AW+1){1'b0}} : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr[AW-1:0] == DEPTH[AW-1:0] - 1'b1) ?
                  {(AW+1){1'b0}} : rd_ptr + 1'b1;
      end
      count <= count + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
    end
  end
endmodule

// ===== design/ipl_link.v
// uart packet framer, deframer and link state machine
`timescale 1ns/1ps
`include "ipl_map.vh"
module ipl_link #(
  parameter BIT_CYC     = `IPL_BIT_CYC,
  parameter TIMEOUT_CYC = `IPL_TIMEOUT_CYC,
  parameter VER_LEN     = 4,
  parameter [8*VER_LEN-1:0] VERSION = 32'h31_2e_30_30,
  parameter [7:0] PATTERN = 8'h5a
) (
  input  wire       i_clk,
  input  wire       i_sys_rst,
  input  wire       i_rxd,
  output reg        o_txd,
  output wire [7:0] o_rx_data,
  output wire       o_rx_valid,
  output wire       o_rx_first,
  input  wire       i_rx_ready,
  input  wire       i_local_done,
  input  wire       i_model_done,
  output reg  [2:0] o_link_state,
  output reg        o_timeout,
  output reg        o_crc_err
);
  // ----------------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------------
  function [7:0] crc_step;
    input [7:0] c;
    input [7:0] d;
    integer k;
    reg [7:0] r;
    begin
      r = c ^ d;
      for (k = 0; k < 8; k = k + 1) begin
        r = r[7] ? ((r << 1) ^ `IPL_CRC_POLY) : (r << 1); // [R5] [R19]
      end
      crc_step = r;
    end
  endfunction

  localparam [2:0] ST_INIT = 3'd0;
  localparam [2:0] ST_SYNC = 3'd1;
  localparam [2:0] ST_LOCL = 3'd2;
  localparam [2:0] ST_MODL = 3'd3;
  localparam [2:0] ST_OPER = 3'd4;
  localparam [15:0] BITC = BIT_CYC[15:0];

  // ----------------------------------------------------------------------
  // uart receiver, 8n1
  // ----------------------------------------------------------------------
  reg        rx_m;
  reg        rx_s;
  reg [15:0] rx_cnt;
  reg [3:0]  rx_bit;
  reg        rx_busy;
  reg [7:0]  rx_sh;
  reg        rx_stb;
  reg [7:0]  rx_byte;
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      rx_m <= 1'b1;
      rx_s <= 1'b1;
      rx_cnt <= 16'h0000;
      rx_bit <= 4'h0;
      rx_busy <= 1'b0;
      rx_sh <= 8'h00;
      rx_stb <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      rx_m <= i_rxd;
      rx_s <= rx_m;
      rx_stb <= 1'b0;
      if (!rx_busy) begin
        if (!rx_s) begin
          rx_busy <= 1'b1;
          rx_cnt <= {1'b0, BITC[15:1]};
          rx_bit <= 4'h0;
        end
      end else if (rx_cnt != 16'h0000) begin
        rx_cnt <= rx_cnt - 16'h0001;
      end else begin
        rx_cnt <= BITC - 16'h0001; // [R7]
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0 && rx_s) begin
          rx_busy <= 1'b0;
        end else if (rx_bit == 4'h9) begin
          rx_busy <= 1'b0;
          rx_stb <= rx_s;
          rx_byte <= rx_sh;
        end else begin
          rx_sh <= {rx_s, rx_sh[7:1]};
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // deframer; payload held until end delimiter checks out
  // ----------------------------------------------------------------------
  localparam [2:0] DF_S0 = 3'd0;
  localparam [2:0] DF_S1 = 3'd1;
  localparam [2:0] DF_CMD = 3'd2;
  localparam [2:0] DF_LEN = 3'd3;
  localparam [2:0] DF_PAY = 3'd4;
  localparam [2:0] DF_CRC = 3'd5;
  localparam [2:0] DF_END = 3'd6;
  localparam [2:0] DF_OUT = 3'd7;
  reg [2:0] df_st;
  reg [7:0] df_crc;
  reg [7:0] df_len;
  reg [7:0] df_idx;
  reg       df_ok;
  reg [8:0] df_oi;
  reg [7:0] pk [0:256];
  wire      q_ready;
  wire      q_valid;
  wire      q_first;
  always @(posedge i_clk) begin
    if (rx_stb && df_st != DF_OUT) begin
      if (df_st == DF_CMD) pk[0] <= rx_byte;
      if (df_st == DF_PAY) pk[df_idx + 9'd1] <= rx_byte;
    end
  end
  assign q_valid = (df_st == DF_OUT);
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      df_st <= DF_S0;
      df_crc <= `IPL_CRC_INIT;
      df_len <= 8'h00;
      df_idx <= 8'h00;
      df_ok <= 1'b0;
      df_oi <= 9'h000;
      o_crc_err <= 1'b0;
    end else begin
      o_crc_err <= 1'b0;
      if (df_st == DF_OUT) begin
        if (q_ready) begin
          df_oi <= df_oi + 9'h001;
          if (df_oi == {1'b0, df_len}) df_st <= DF_S0;
        end
      end else if (rx_stb) begin
        case (df_st)
          DF_S0: if (rx_byte == `IPL_SOF0) df_st <= DF_S1; // [R1]
          DF_S1: df_st <= (rx_byte == `IPL_SOF1) ? DF_CMD :
                          (rx_byte == `IPL_SOF0) ? DF_S1 : DF_S0;
          DF_CMD: begin // [R2] [R11]
            df_crc <= crc_step(`IPL_CRC_INIT, rx_byte);
            df_st <= DF_LEN;
          end
          DF_LEN: begin // [R3] [R4]
            df_crc <= crc_step(df_crc, rx_byte);
            df_len <= rx_byte;
            df_idx <= 8'h00;
            df_st <= (rx_byte == 8'h00) ? DF_CRC : DF_PAY;
          end
          DF_PAY: begin
            df_crc <= crc_step(df_crc, rx_byte);
            df_idx <= df_idx + 8'h01;
            if (df_idx + 8'h01 == df_len) df_st <= DF_CRC; // [R3]
          end
          DF_CRC: begin
            df_ok <= (rx_byte == (df_crc ^ `IPL_CRC_XOR)); // [R5]
            df_st <= DF_END;
          end
          DF_END: begin
            df_oi <= 9'h000;
            if (df_ok && rx_byte == `IPL_EOF) begin // [R6] [R9]
              df_st <= DF_OUT;
            end else begin
              o_crc_err <= 1'b1; // [R18]
              df_st <= DF_S0;
            end
          end
          default: df_st <= DF_S0;
        endcase
      end
    end
  end

  // bytes arriving during hand-off are lost; the fifo below the consumer
  // keeps the hand-off short while the consumer drains
  ipl_fifo #(.WIDTH(9), .DEPTH(`IPL_FIFO_DEPTH), .AW(5)) u_q ( // [R8]
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_data    ({df_oi == 9'h000, pk[df_oi]}),
    .i_valid   (q_valid),
    .o_ready   (q_ready),
    .o_data    ({q_first, o_rx_data}),
    .o_valid   (o_rx_valid),
    .i_ready   (i_rx_ready)
  );

  // ----------------------------------------------------------------------
  // stream flag
  // ----------------------------------------------------------------------
  // an empty fifo still shows a stale slot, so the flag is masked by valid
  assign o_rx_first = q_first & o_rx_valid; // [R9]

  // ----------------------------------------------------------------------
  // handshake framer and uart transmitter
  // ----------------------------------------------------------------------
  localparam [7:0] VLEN    = VER_LEN[7:0];
  localparam [7:0] HS_LEN  = VLEN + 8'd1;
  localparam [7:0] HS_LAST = VLEN + 8'd6;
  reg [7:0]  tx_idx;
  reg        tx_act;
  reg [7:0]  tx_crc;
  reg [9:0]  tx_sh;
  reg [3:0]  tx_bit;
  reg [15:0] tx_cnt;
  reg        tx_done;
  reg [7:0]  hs_byte;
  always @* begin
    if (tx_idx == 8'd0) hs_byte = `IPL_SOF0; // [R1]
    else if (tx_idx == 8'd1) hs_byte = `IPL_SOF1;
    else if (tx_idx == 8'd2) hs_byte = `IPL_CMD_HELLO; // [R16]
    else if (tx_idx == 8'd3) hs_byte = HS_LEN;
    else if (tx_idx == 8'd4) hs_byte = PATTERN;
    else if (tx_idx < HS_LAST - 8'd1)
      hs_byte = VERSION[8*(HS_LAST-8'd2-tx_idx) +: 8]; // [R13]
    else if (tx_idx == HS_LAST - 8'd1) hs_byte = tx_crc ^ `IPL_CRC_XOR;
    else hs_byte = `IPL_EOF; // [R6]
  end
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_txd <= 1'b1;
      tx_idx <= 8'h00;
      tx_act <= 1'b0;
      tx_crc <= `IPL_CRC_INIT;
      tx_sh <= 10'h3ff;
      tx_bit <= 4'h0;
      tx_cnt <= 16'h0000;
      tx_done <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      if (tx_cnt != 16'h0000) begin
        tx_cnt <= tx_cnt - 16'h0001;
      end else if (tx_bit != 4'h0) begin
        o_txd <= tx_sh[0]; // [R7]
        tx_sh <= {1'b1, tx_sh[9:1]};
        tx_bit <= tx_bit - 4'h1;
        tx_cnt <= BITC - 16'h0001;
      end else if (tx_act) begin
        tx_sh <= {1'b1, hs_byte, 1'b0};
        tx_bit <= 4'ha;
        if (tx_idx >= 8'd2 && tx_idx < HS_LAST - 8'd1)
          tx_crc <= crc_step(tx_crc, hs_byte); // [R19]
        if (tx_idx == HS_LAST) begin
          tx_act <= 1'b0;
          tx_done <= 1'b1;
        end
        tx_idx <= tx_idx + 8'h01;
      end else if (o_link_state == ST_SYNC && !tx_done) begin
        tx_act <= 1'b1;
        tx_idx <= 8'h00;
        tx_crc <= `IPL_CRC_INIT;
      end
    end
  end

  // ----------------------------------------------------------------------
  // link state machine and receive timeout
  // ----------------------------------------------------------------------
  localparam [31:0] TO_LAST = TIMEOUT_CYC - 1;
  reg [31:0] to_cnt;
  reg [2:0]  next_link_state;
  // operation is final; only a reset brings the link back to init
  always @* begin
    case (o_link_state)
      ST_INIT: next_link_state = ST_SYNC; // [R12]
      ST_SYNC: next_link_state = tx_done ? ST_LOCL : ST_SYNC; // [R14]
      ST_LOCL: next_link_state = i_local_done ? ST_MODL : ST_LOCL; // [R17]
      ST_MODL: next_link_state = i_model_done ? ST_OPER : ST_MODL;
      ST_OPER: next_link_state = ST_OPER;
      default: next_link_state = ST_INIT;
    endcase
  end

  // the timer is held clear in init and sync and restarts when a byte is queued, not while one arrives
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_link_state <= ST_INIT;
      to_cnt <= 32'h0;
      o_timeout <= 1'b0;
    end else begin
      o_link_state <= next_link_state;
      // [R10] [R19] timeout after last delivered packet
      o_timeout <= 1'b0;
      if (o_link_state == ST_INIT || o_link_state == ST_SYNC ||
          (q_valid && q_ready)) begin
        to_cnt <= 32'h0;
      end else if (to_cnt == TO_LAST) begin
        o_timeout <= 1'b1;
        to_cnt <= 32'h0;
      end else begin
        to_cnt <= to_cnt + 32'h1;
      end
    end
  end
endmodule

// ===== test/ipl_link_props.sv
// port assertions for the packet link
`timescale 1ns/1ps
module ipl_link_props (
  input wire logic       i_clk,
  input wire logic       i_sys_rst,
  input wire logic       o_txd,
  input wire logic [7:0] o_rx_data,
  input wire logic       o_rx_valid,
  input wire logic       o_rx_first,
  input wire logic       i_rx_ready,
  input wire logic       i_local_done,
  input wire logic       i_model_done,
  input wire logic [2:0] o_link_state,
  input wire logic       o_timeout,
  input wire logic       o_crc_err
);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  chk_reset_clear: assert property ($fell(i_sys_rst) |-> o_txd &&
    o_link_state == 3'h0 && !o_rx_valid && !o_crc_err)
    else $error("outputs not cleared by reset");
  chk_sync_hello: assert property ($fell(i_sys_rst) |=>
    o_link_state == 3'h1 ##[0:3] !o_txd)
    else $error("no sync state or handshake start");
  chk_sync_next: assert property (o_link_state == 3'h1 |=>
    o_link_state inside {3'h1, 3'h2})
    else $error("bad exit from sync state");
  chk_local_hold: assert property (
    o_link_state == 3'h2 && !i_local_done |=> o_link_state == 3'h2)
    else $error("left local exchange early");
  chk_model_hold: assert property (
    o_link_state == 3'h3 && !i_model_done |=> o_link_state == 3'h3)
    else $error("left model exchange early");
  chk_op_final: assert property (o_link_state == 3'h4 |=>
    $stable(o_link_state))
    else $error("operation state left");
  chk_first_valid: assert property (o_rx_first |-> o_rx_valid)
    else $error("first flag without data");
  chk_data_stall: assert property (o_rx_valid && !i_rx_ready |=>
    o_rx_valid && $stable(o_rx_data) && $stable(o_rx_first))
    else $error("data changed while stalled");
  chk_err_pulse: assert property (o_crc_err |=> !o_crc_err)
    else $error("drop flag longer than one cycle");
  chk_tmo_pulse: assert property (o_timeout |->
    o_link_state >= 3'h2 ##1 !o_timeout)
    else $error("bad timeout pulse");
  cover property (o_crc_err);
  cover property (o_rx_first && i_rx_ready);
  cover property (o_timeout);
  cover property (o_link_state == 3'h4);
endmodule

// ===== test/ipl_peer.sv
// uart model of the communication processor across the link
`timescale 1ns/1ps
module ipl_peer #(
  parameter BIT_CYC = 16
) (
  input  wire logic i_clk,
  input  wire logic i_txd,
  output logic      o_rxd
);
  // ------------------------------------------------------------
  // sender and receiver
  // ------------------------------------------------------------
  logic [7:0] rx_q[$];
  logic [7:0] sh;
  initial o_rxd = 1'b1;
  function automatic logic [7:0] crc_step(logic [7:0] c, logic [7:0] d);
    c = c ^ d;
    for (int k = 0; k < 8; k++)
      c = c[7] ? {c[6:0], 1'b0} ^ 8'h31 : {c[6:0], 1'b0};
    return c;
  endfunction
  task automatic put(logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      o_rxd = f[i];
      repeat (BIT_CYC) @(posedge i_clk);
      #1;
    end
  endtask
  // mode 1 bad crc, 2 bad end, 3 noise before the delimiter
  task automatic send_pkt(logic [7:0] cmd, logic [7:0] len, int mode);
    logic [7:0] c;
    c = 8'hff;
    if (mode == 3)
      put(8'hef);
    if (mode == 3)
      put(8'h11);
    put(8'hef);
    put(8'hbe);
    put(cmd);
    c = crc_step(c, cmd);
    put(len);
    c = crc_step(c, len);
    for (int k = 0; k < len; k++) begin
      put(cmd ^ k[7:0]);
      c = crc_step(c, cmd ^ k[7:0]);
    end
    put(mode == 1 ? ~c : c);
    put(mode == 2 ? 8'h0a : 8'h0d);
  endtask
  // samples mid-bit; a bad stop bit drops the byte
  initial begin
    forever begin
      @(negedge i_txd);
      repeat (BIT_CYC + BIT_CYC / 2) @(posedge i_clk);
      for (int i = 0; i < 8; i++) begin
        sh[i] = i_txd;
        repeat (BIT_CYC) @(posedge i_clk);
      end
      if (i_txd === 1'b1)
        rx_q.push_back(sh);
    end
  end
endmodule

// ===== test/ipl_link_tb.sv
// self-checking bench for the packet link
`timescale 1ns/1ps
module ipl_link_tb;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       rdy = 1'b0;
  logic       ldone = 1'b0;
  logic       mdone = 1'b0;
  wire        rxd, txd, rvalid, rfirst, tmo, cerr;
  wire  [7:0] rdata;
  wire  [2:0] st;
  int         n_fail = 0;
  int         checked = 0;
  int         n_err = 0;
  int         n;
  // cmd, len, mode, packet queued
  int rows[6][4] = '{'{5, 0, 0, 1}, '{6, 1, 0, 1}, '{7, 0, 1, 0},
                     '{8, 31, 3, 1}, '{17, 4, 2, 0}, '{11, 2, 0, 1}};
  always #25 clk = ~clk;
  always @(posedge clk) if (cerr === 1'b1) n_err++;
  ipl_link #(.BIT_CYC(16), .TIMEOUT_CYC(2000)) i_ipl_link (
    .i_clk(clk), .i_sys_rst(rst), .i_rxd(rxd), .o_txd(txd),
    .o_rx_data(rdata), .o_rx_valid(rvalid), .o_rx_first(rfirst),
    .i_rx_ready(rdy), .i_local_done(ldone), .i_model_done(mdone),
    .o_link_state(st), .o_timeout(tmo), .o_crc_err(cerr));
  ipl_peer #(.BIT_CYC(16)) i_ipl_peer (.i_clk(clk), .i_txd(txd),
    .o_rxd(rxd));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic end_sim;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(logic [7:0] g, logic [7:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  // bounded wait: 1 state, 2 rx valid, 3 peer bytes
  task automatic wait_for(int what, int v);
    n = 0;
    while (!(what == 1 ? st === v : what == 2 ? rvalid === 1'b1 :
             i_ipl_peer.rx_q.size() >= v)) begin
      n++;
      if (n > 30000) begin
        n_fail++;
        end_sim();
      end
      tick();
    end
  endtask
  task automatic hello;
    logic [7:0] hs[11];
    logic [7:0] c;
    hs = '{8'hef, 8'hbe, 8'h02, 8'h05, 8'h5a, 8'h31, 8'h2e, 8'h30,
           8'h30, 8'h00, 8'h0d};
    c = 8'hff;
    wait_for(3, 11);
    for (int k = 0; k < 11; k++) begin
      if (k >= 2 && k < 9)
        c = i_ipl_peer.crc_step(c, hs[k]);
      cmp(i_ipl_peer.rx_q[k], k == 9 ? c : hs[k]);
    end
    cmp({5'h0, st}, 8'h02);
  endtask
  task automatic drain(logic [7:0] cmd, int len);
    for (int k = 0; k <= len; k++) begin
      cmp({7'h0, rfirst}, {7'h0, k == 0});
      cmp(rdata, k == 0 ? cmd : cmd ^ (k - 1));
      rdy = 1'b1;
      tick();
      rdy = 1'b0;
      tick();
    end
    cmp({7'h0, rvalid}, 8'h00);
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    hello();
    ldone = 1'b1;
    wait_for(1, 3);
    mdone = 1'b1;
    wait_for(1, 4);
    // consumer stalls through each packet; 32 bytes match the buffer depth
    foreach (rows[r]) begin
      n_err = 0;
      i_ipl_peer.send_pkt(rows[r][0], rows[r][1], rows[r][2]);
      if (rows[r][3] == 1)
        wait_for(2, 0);
      if (rows[r][3] == 1)
        drain(rows[r][0], rows[r][1]);
      cmp({7'h0, rvalid}, 8'h00);
      cmp(n_err[7:0], {7'h0, rows[r][3] == 0});
    end
    i_ipl_peer.send_pkt(8'h0b, 8'h00, 0);
    wait_for(2, 0);
    drain(8'h0b, 0);
    n = 0;
    while (tmo !== 1'b1 && n < 3000) begin
      n++;
      tick();
    end
    cmp({7'h0, n >= 1990 && n <= 2000}, 8'h01);
    rst = 1'b1;
    // the exchange levels drop with the restart, or the link runs on
    ldone = 1'b0;
    mdone = 1'b0;
    repeat (3) tick();
    i_ipl_peer.rx_q.delete();
    rst = 1'b0;
    cmp({7'h0, rvalid}, 8'h00);
    hello();
    end_sim();
  end
endmodule
bind ipl_link ipl_link_props i_ipl_link_props (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .o_txd(o_txd),
  .o_rx_data(o_rx_data), .o_rx_valid(o_rx_valid), .o_rx_first(o_rx_first),
  .i_rx_ready(i_rx_ready), .i_local_done(i_local_done),
  .i_model_done(i_model_done), .o_link_state(o_link_state),
  .o_timeout(o_timeout), .o_crc_err(o_crc_err));
